//--- design/timer_flags_pkg.sv
// package for the timer event-flag block: register map, field positions,
// reset values, channel modes and counter direction.
// assumes a single 20 MHz system clock and a plain word-wide register port.
package timer_flags_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 2;              // capture/compare channels
  localparam int NUM_FLAGS = NUM_CH + 1;  // overflow flag plus one per channel
  localparam int DATA_W = 16;             // register port data width
  localparam int ADDR_W = 8;              // register port address width
  localparam int PRESC_W = 7;             // prescaler counter width

  // ----------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;     // run, center select, prescale
  localparam logic [7:0] ADDR_MOD = 8'h01;      // modulus limit, 0 = free run in up mode, hold at zero in up/down
  localparam logic [7:0] ADDR_CNT = 8'h02;      // counter; any write restarts at zero
  localparam logic [7:0] ADDR_FLAGS = 8'h03;    // event flags, read then write 0
  localparam logic [7:0] ADDR_IRQ_EN = 8'h04;   // interrupt enables, same layout
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;  // channel n control at base + 2n
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h02;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CENTER_BIT = 1;
  localparam int CTRL_PRESC_LSB = 2;        // three bits, divide by 2^n
  localparam int FLAG_OVF_BIT = 0;          // channel n flag at bit n + 1
  localparam int CH_MODE_LSB = 0;           // two bits
  localparam int CH_ELS_A_BIT = 2;
  localparam int CH_ELS_B_BIT = 3;

  // ----------------------------------------------------------------
  // reset values and fixed counts
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] VAL_RESET = 16'h0000;
  localparam logic [2:0] PRESC_RESET = 3'h0;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'h0,
    MODE_COMPARE = 2'h1,
    MODE_PWM = 2'h2,
    MODE_OFF = 2'h3
  } ch_mode_t;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

endpackage

//--- design/timer_flags.sv
// timer counter with overflow and per-channel event flags, interrupt request
// and a plain register port (address, strobes, read data one cycle later).
// assumes channel inputs already synchronous to sys_clk and a master that
// never issues read and write strobes in the same cycle.
`timescale 1ns/10ps

// Contract
// RQ1: up mode free run wraps FFFF to 0000
// RQ2: free run overflow flag at FFFF to 0000
// RQ3: modulus set: flag at modulus to 0000
// RQ4: up/down: flag on reversal from modulus down
// RQ5: edge select bits pick rise, fall, both, off
// RQ6: capture channel flag on selected edge
// RQ7: compare channel flag on counter equal value
// RQ8: edge pwm flag on match ending duty
// RQ9: center pwm flag at both matches
// RQ10: flags stay set until two-step clear completes
// RQ11: read flag as one, then write zero
// RQ12: event between steps restarts clear, flag stays
// RQ13: level irq while enabled flag is one
// RQ14: center select chooses up or up/down counting
// RQ15: flags evaluated on counting clock, reset zero; capture flags are set on any sys_clk edge
module timer_flags
  import timer_flags_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [NUM_CH-1:0] ch_in,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq
);

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------

  // control word address of channel n
  function automatic logic [7:0] ch_ctrl_addr(input int n);
    ch_ctrl_addr = 8'(ADDR_CH_BASE + ADDR_CH_STRIDE * 8'(n));
  endfunction

  // value word address of channel n, right after its control word
  function automatic logic [7:0] ch_val_addr(input int n);
    ch_val_addr = 8'(ch_ctrl_addr(n) + 8'h01);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic run_r, run_nxt;                         // counter running
  logic center_aligned_select_r, center_aligned_select_nxt;
  logic [2:0] presc_sel_r, presc_sel_nxt;       // divide by 2^n
  logic [PRESC_W-1:0] presc_cnt_r, presc_cnt_nxt;
  logic [15:0] mod_r, mod_nxt;                  // modulus limit
  logic [15:0] cnt_r, cnt_nxt;                  // main counter
  dir_t dir_r, dir_nxt;                         // up/down direction
  ch_mode_t ch_mode_r [NUM_CH];
  ch_mode_t ch_mode_nxt [NUM_CH];
  logic [NUM_CH-1:0] edge_level_select_a_r, edge_level_select_a_nxt;
  logic [NUM_CH-1:0] edge_level_select_b_r, edge_level_select_b_nxt;
  logic [15:0] ch_val_r [NUM_CH];               // compare value or captured count
  logic [15:0] ch_val_nxt [NUM_CH];
  logic [NUM_CH-1:0] in_prev_r, in_prev_nxt;    // last sampled channel level
  logic [NUM_FLAGS-1:0] flags_r, flags_nxt;     // overflow + channel flags
  logic [NUM_FLAGS-1:0] armed_r, armed_nxt;     // first clear step seen
  logic [NUM_FLAGS-1:0] irq_en_r, irq_en_nxt;   // per-flag interrupt enable
  logic [DATA_W-1:0] rdata_nxt;
  logic irq_nxt;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic tick;                       // one-cycle counting clock enable
  logic [PRESC_W-1:0] presc_lim;    // last prescaler count of a period
  logic [NUM_CH-1:0] rise;          // channel rising edge this cycle
  logic [NUM_CH-1:0] fall;          // channel falling edge this cycle
  logic [NUM_FLAGS-1:0] evt;        // flag-setting events this cycle
  logic [NUM_FLAGS-1:0] clr;        // completed clear sequences

  assign presc_lim = PRESC_W'((8'h01 << presc_sel_r) - 8'h01);
  assign tick = run_r && (presc_cnt_r == presc_lim);

  // ----------------------------------------------------------------
  // channel edge detection
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_edge
      // inputs are synchronous already, so one history flop suffices
      assign rise[g] = ch_in[g] && !in_prev_r[g];
      assign fall[g] = !ch_in[g] && in_prev_r[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    run_nxt = run_r;
    center_aligned_select_nxt = center_aligned_select_r;
    presc_sel_nxt = presc_sel_r;
    mod_nxt = mod_r;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    edge_level_select_a_nxt = edge_level_select_a_r;
    edge_level_select_b_nxt = edge_level_select_b_r;
    irq_en_nxt = irq_en_r;
    in_prev_nxt = ch_in;
    evt = '0;
    clr = '0;
    rdata_nxt = '0;
    for (int n = 0; n < NUM_CH; n++) begin
      ch_mode_nxt[n] = ch_mode_r[n];
      ch_val_nxt[n] = ch_val_r[n];
    end

    // prescaler: restarts whenever stopped so the first tick is a full period
    if (tick || !run_r) begin
      presc_cnt_nxt = '0;
    end else begin
      presc_cnt_nxt = PRESC_W'(presc_cnt_r + 1'b1);
    end

    // counter advances only on the counting clock enable
    if (tick) begin // RQ15
      if (!center_aligned_select_r) begin // RQ14
        if (mod_r == MOD_RESET) begin
          // free run: wrap FFFF to 0000 and flag it
          if (cnt_r == CNT_TOP) begin
            cnt_nxt = CNT_ZERO; // RQ1
            evt[FLAG_OVF_BIT] = 1'b1; // RQ2
          end else begin
            cnt_nxt = cnt_r + CNT_ONE; // RQ1
          end
        end else if (cnt_r == mod_r) begin
          cnt_nxt = CNT_ZERO;
          evt[FLAG_OVF_BIT] = 1'b1; // RQ3
        end else begin
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end else begin
        // up/down: a zero modulus cannot reverse, so hold at zero
        case (dir_r)
          DIR_UP: begin
            if (mod_r == MOD_RESET) begin
              cnt_nxt = CNT_ZERO;
            end else if (cnt_r == mod_r) begin
              // reversal marks the end of a period
              cnt_nxt = cnt_r - CNT_ONE;
              dir_nxt = DIR_DOWN;
              evt[FLAG_OVF_BIT] = 1'b1; // RQ4
            end else begin
              cnt_nxt = cnt_r + CNT_ONE;
            end
          end
          DIR_DOWN: begin
            if (cnt_r == CNT_ZERO) begin
              // zero is the period centre, no flag here
              cnt_nxt = CNT_ONE;
              dir_nxt = DIR_UP;
            end else begin
              cnt_nxt = cnt_r - CNT_ONE;
            end
          end
          default: begin
            dir_nxt = DIR_UP;
          end
        endcase
      end
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          run_nxt = reg_wdata[CTRL_RUN_BIT];
          center_aligned_select_nxt = reg_wdata[CTRL_CENTER_BIT]; // RQ14
          presc_sel_nxt = reg_wdata[CTRL_PRESC_LSB +: 3];
        end
        ADDR_MOD: begin
          mod_nxt = reg_wdata;
        end
        ADDR_CNT: begin
          // restart the period from zero counting up
          cnt_nxt = CNT_ZERO;
          dir_nxt = DIR_UP;
        end
        ADDR_IRQ_EN: begin
          irq_en_nxt = reg_wdata[NUM_FLAGS-1:0];
        end
        default: begin
          for (int n = 0; n < NUM_CH; n++) begin
            if (reg_addr == ch_ctrl_addr(n)) begin
              ch_mode_nxt[n] = ch_mode_t'(reg_wdata[CH_MODE_LSB +: 2]);
              edge_level_select_a_nxt[n] = reg_wdata[CH_ELS_A_BIT];
              edge_level_select_b_nxt[n] = reg_wdata[CH_ELS_B_BIT];
            end
            if (reg_addr == ch_val_addr(n)) begin
              ch_val_nxt[n] = reg_wdata;
            end
          end
        end
      endcase
    end

    // channel events; a capture overrides a same-cycle value write
    for (int n = 0; n < NUM_CH; n++) begin
      case (ch_mode_r[n])
        MODE_CAPTURE: begin
          // a selects rising, b selects falling, both = either, none = off
          if ((edge_level_select_a_r[n] && rise[n]) ||
              (edge_level_select_b_r[n] && fall[n])) begin // RQ5
            ch_val_nxt[n] = cnt_r;
            evt[n + 1] = 1'b1; // RQ6
          end
        end
        MODE_COMPARE: begin
          if (tick && cnt_r == ch_val_r[n]) begin
            evt[n + 1] = 1'b1; // RQ7
          end
        end
        MODE_PWM: begin
          // up mode matches once (end of duty); up/down passes twice
          if (tick && cnt_r == ch_val_r[n]) begin
            evt[n + 1] = 1'b1; // RQ8 RQ9
          end
        end
        default: begin
          // channel off: no events
          evt[n + 1] = 1'b0;
        end
      endcase
    end

    // two-step clear: read arms set flags, write of zero clears armed ones
    armed_nxt = armed_r;
    if (reg_rd && reg_addr == ADDR_FLAGS) begin
      armed_nxt = flags_r; // RQ11
    end else if (reg_wr && reg_addr == ADDR_FLAGS) begin
      clr = armed_r & ~reg_wdata[NUM_FLAGS-1:0]; // RQ11
      armed_nxt = '0;
    end
    // a new event disarms, so the flag survives the pending write
    armed_nxt = armed_nxt & ~evt; // RQ12
    clr = clr & ~evt; // RQ12

    // set wins over clear; nothing else lowers a flag
    flags_nxt = (flags_r & ~clr) | evt; // RQ10

    // level request from registered next values, one flop to the pin
    irq_nxt = |(flags_nxt & irq_en_nxt); // RQ13

    // read data: valid only in the cycle after the read strobe
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          rdata_nxt[CTRL_RUN_BIT] = run_r;
          rdata_nxt[CTRL_CENTER_BIT] = center_aligned_select_r;
          rdata_nxt[CTRL_PRESC_LSB +: 3] = presc_sel_r;
        end
        ADDR_MOD: begin
          rdata_nxt = mod_r;
        end
        ADDR_CNT: begin
          rdata_nxt = cnt_r;
        end
        ADDR_FLAGS: begin
          rdata_nxt[NUM_FLAGS-1:0] = flags_r;
        end
        ADDR_IRQ_EN: begin
          rdata_nxt[NUM_FLAGS-1:0] = irq_en_r;
        end
        default: begin
          // unmapped addresses read zero
          for (int n = 0; n < NUM_CH; n++) begin
            if (reg_addr == ch_ctrl_addr(n)) begin
              rdata_nxt[CH_MODE_LSB +: 2] = ch_mode_r[n];
              rdata_nxt[CH_ELS_A_BIT] = edge_level_select_a_r[n];
              rdata_nxt[CH_ELS_B_BIT] = edge_level_select_b_r[n];
            end
            if (reg_addr == ch_val_addr(n)) begin
              rdata_nxt = ch_val_r[n];
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_r <= 1'b0;
      center_aligned_select_r <= 1'b0;
      presc_sel_r <= PRESC_RESET;
      presc_cnt_r <= '0;
      mod_r <= MOD_RESET;
      cnt_r <= CNT_ZERO;
      dir_r <= DIR_UP;
      edge_level_select_a_r <= '0;
      edge_level_select_b_r <= '0;
      in_prev_r <= '0;
      flags_r <= '0; // RQ15
      armed_r <= '0;
      irq_en_r <= '0;
      reg_rdata <= '0;
      irq <= 1'b0;
      for (int n = 0; n < NUM_CH; n++) begin
        ch_mode_r[n] <= MODE_OFF;
        ch_val_r[n] <= VAL_RESET;
      end
    end else begin
      run_r <= run_nxt;
      center_aligned_select_r <= center_aligned_select_nxt;
      presc_sel_r <= presc_sel_nxt;
      presc_cnt_r <= presc_cnt_nxt;
      mod_r <= mod_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      edge_level_select_a_r <= edge_level_select_a_nxt;
      edge_level_select_b_r <= edge_level_select_b_nxt;
      in_prev_r <= in_prev_nxt;
      flags_r <= flags_nxt;
      armed_r <= armed_nxt;
      irq_en_r <= irq_en_nxt;
      reg_rdata <= rdata_nxt;
      irq <= irq_nxt;
      for (int n = 0; n < NUM_CH; n++) begin
        ch_mode_r[n] <= ch_mode_nxt[n];
        ch_val_r[n] <= ch_val_nxt[n];
      end
    end
  end

endmodule // timer_flags

//--- testbench/timer_flags_sva.sv
// checker for the timer flag block, watching only its top-level ports.
// assumes one-cycle strobes, never both high in one cycle.
`timescale 1ns/10ps
module timer_flags_chk
  import timer_flags_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [NUM_CH-1:0] ch_in,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  // ------------------------------------------------------------
  // shadow state
  // ------------------------------------------------------------
  logic [NUM_FLAGS-1:0] en_r, en_nxt; // copy of irq enables
  logic [NUM_FLAGS-1:0] seen_r, seen_nxt; // flags on last read
  logic hold_r, hold_nxt; // no flag write since that read
  logic frd_r, frd_nxt; // flag read data due now
  wire logic unmapped = !(reg_addr <= ADDR_IRQ_EN ||
    (reg_addr >= ADDR_CH_BASE && reg_addr < 8'h14));
  // next shadow values; a flag write drops the hold since clears may follow
  always_comb begin
    en_nxt = en_r;
    seen_nxt = seen_r;
    hold_nxt = hold_r;
    frd_nxt = reg_rd && reg_addr == ADDR_FLAGS;
    if (reg_wr && reg_addr == ADDR_IRQ_EN) begin
      en_nxt = reg_wdata[NUM_FLAGS-1:0];
    end
    if (frd_r) begin
      seen_nxt = reg_rdata[NUM_FLAGS-1:0];
      hold_nxt = 1'b1;
    end
    if (reg_wr && reg_addr == ADDR_FLAGS) begin
      hold_nxt = 1'b0;
    end
  end
  // register only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      en_r <= '0;
      seen_r <= '0;
      hold_r <= 1'b0;
      frd_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      seen_r <= seen_nxt;
      hold_r <= hold_nxt;
      frd_r <= frd_nxt;
    end
  end
  // ------------------------------------------------------------
  // sequences and assertions
  // ------------------------------------------------------------
  sequence s_flag_read;
    reg_rd && reg_addr == ADDR_FLAGS ##1 1'b1;
  endsequence
  sequence s_cnt_restart;
    reg_wr && reg_addr == ADDR_CNT ##1 reg_rd && reg_addr == ADDR_CNT;
  endsequence
  a_reset_irq_low: assert property (rst |=> !irq)
    else $error("irq high after reset");
  a_reset_rdata: assert property (rst |=> reg_rdata == '0)
    else $error("read data not zero after reset");
  a_rdata_idle: assert property (disable iff (rst) !reg_rd |=> reg_rdata == '0)
    else $error("read data without read");
  a_unmapped_zero: assert property (disable iff (rst)
    reg_rd && unmapped |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_irq_on_flag: assert property (disable iff (rst)
    s_flag_read ##0 (|(reg_rdata[NUM_FLAGS-1:0] & en_r)) |-> ##[0:1] irq)
    else $error("enabled flag set but no irq");
  a_irq_needs_en: assert property (disable iff (rst) (en_r == '0) [*3] |-> !irq)
    else $error("irq with all enables off");
  a_cnt_restart: assert property (disable iff (rst) s_cnt_restart |=> reg_rdata <= CNT_ONE)
    else $error("counter not restarted");
  a_flags_sticky: assert property (disable iff (rst)
    frd_r && hold_r |-> (reg_rdata[NUM_FLAGS-1:0] & seen_r) == seen_r)
    else $error("flag lost without clear");
endmodule // timer_flags_chk

bind timer_flags timer_flags_chk i_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .ch_in(ch_in),
  .reg_rdata(reg_rdata), .irq(irq));

//--- testbench/cpu_model.sv
// processor side: register port master and interrupt wait.
// assumes tasks are called in the time step of a rising edge.
`timescale 1ns/10ps
module cpu_model
  import timer_flags_pkg::*;
(
  input wire logic sys_clk,
  input wire logic irq,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // bus idle from time zero
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one access; each signal set once per step, so accesses chain with no gap
  task automatic access(input logic w, input logic r, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask
  // drop strobes and let n edges pass
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  // read flags, then write zero to every bit
  task automatic clear_flags();
    access(1'b0, 1'b1, ADDR_FLAGS, '0);
    access(1'b1, 1'b0, ADDR_FLAGS, '0);
  endtask
  // bounded wait for the interrupt level, sampled mid-cycle
  task automatic wait_irq(input int bound, output bit hit);
    hit = 1'b0;
    idle(0);
    for (int i = 0; i < bound && !hit; i++) begin
      @(negedge sys_clk);
      hit = irq === 1'b1;
    end
    @(posedge sys_clk);
  endtask
endmodule // cpu_model

//--- testbench/timer_flags_tb.sv
// self-checking bench for the timer flag block.
// assumes the processor model drives the register port.
`timescale 1ns/10ps
module timer_flags_tb
  import timer_flags_pkg::*;
;
  typedef struct {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] exp;
    logic [DATA_W-1:0] mask;
  } note_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_CH-1:0] ch_in = '0;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr, reg_rd, irq;
  logic [DATA_W-1:0] reg_rdata;
  logic [DATA_W-1:0] mod_v; // random modulus
  note_t notes[$]; // expected read results, oldest first
  int n_errors = 0;
  int num_checks = 0;
  int seed = 81716;
  bit hit;
  int gap; // length of the last random pause, or the random run length of the prescale test
  logic pend = 1'b0; // read data due this cycle
  logic [7:0] rst_addr [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h12,
    8'h13, 8'h08, 8'h20};
  logic [15:0] rst_val [11] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003,
    16'h0000, 16'h0003, 16'h0000, 16'h0000, 16'h0000};
  always #25 sys_clk = ~sys_clk;
  timer_flags i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .ch_in(ch_in), .reg_rdata(reg_rdata), .irq(irq));
  cpu_model i_cpu (.sys_clk(sys_clk), .irq(irq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    i_cpu.access(1'b1, 1'b0, a, d);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
    input logic [DATA_W-1:0] m);
    notes.push_back('{a, e, m});
    i_cpu.access(1'b0, 1'b1, a, '0);
  endtask
  // clearing read carries no expectation
  task automatic clr();
    notes.push_back('{ADDR_FLAGS, 16'h0000, 16'h0000});
    i_cpu.clear_flags();
  endtask
  task automatic irq_chk(input logic e);
    @(negedge sys_clk);
    check("irq", {15'h0000, e}, {15'h0000, irq});
    @(posedge sys_clk);
  endtask
  task automatic need_irq(input int bound);
    i_cpu.wait_irq(bound, hit);
    num_checks++;
    if (!hit) begin
      n_errors++;
      $display("wrong value irq expected 1 seen 0");
      close_out();
    end
  endtask
  // short random pause with the strobes low; the count is kept in gap
  task automatic pause();
    gap = 1 + ($random(seed) & 3);
    i_cpu.idle(gap);
  endtask
  // read data watcher: data stand the cycle after the strobe
  always @(negedge sys_clk) begin
    if (pend && notes.size() > 0) begin
      if (notes[0].mask != '0) begin
        check($sformatf("register %h", notes[0].addr), notes[0].exp & notes[0].mask,
          reg_rdata & notes[0].mask);
      end
      void'(notes.pop_front());
    end
    pend = reg_rd;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rst_addr[i]) rd_chk(rst_addr[i], rst_val[i], 16'hFFFF);
    $display("test reset values done");
    wr(ADDR_IRQ_EN, 16'h0001);
    wr(ADDR_CTRL, 16'h0001);
    i_cpu.idle(65000 + ($random(seed) & 255));
    rd_chk(ADDR_FLAGS, 16'h0000, 16'h0001);
    need_irq(1000);
    rd_chk(ADDR_FLAGS, 16'h0001, 16'h0001);
    wr(ADDR_CTRL, 16'h0000);
    clr();
    pause();
    irq_chk(1'b0);
    $display("test free run done");
    mod_v = 16'h0004 + 16'($random(seed) & 15);
    wr(ADDR_MOD, mod_v);
    wr(ADDR_CH_BASE, 16'h0001);
    wr(ADDR_CH_BASE + 8'h01, mod_v - 16'h0001);
    wr(ADDR_CH_BASE + 8'h02, 16'h0002);
    wr(ADDR_CH_BASE + 8'h03, 16'h0001);
    wr(ADDR_CNT, 16'h0000);
    rd_chk(ADDR_CNT, 16'h0000, 16'hFFFF);
    clr();
    wr(ADDR_CTRL, 16'h0001);
    i_cpu.idle(2 * mod_v + 4);
    wr(ADDR_CTRL, 16'h0000);
    rd_chk(ADDR_FLAGS, 16'h0007, 16'h0007);
    wr(ADDR_IRQ_EN, 16'h0000);
    pause();
    irq_chk(1'b0);
    wr(ADDR_IRQ_EN, 16'h0002);
    pause();
    irq_chk(1'b1);
    clr();
    rd_chk(ADDR_FLAGS, 16'h0000, 16'h0007);
    $display("test modulus and match done");
    wr(ADDR_MOD, 16'h0003);
    wr(ADDR_CTRL, 16'h0001);
    i_cpu.idle(6);
    rd_chk(ADDR_FLAGS, 16'h0001, 16'h0001);
    i_cpu.idle(6);
    wr(ADDR_FLAGS, 16'h0000);
    wr(ADDR_CTRL, 16'h0000);
    rd_chk(ADDR_FLAGS, 16'h0001, 16'h0001);
    $display("test clear race done");
    wr(ADDR_CNT, 16'h0000);
    wr(ADDR_MOD, 16'h0005);
    wr(ADDR_CH_BASE, 16'h0003);
    wr(ADDR_CH_BASE + 8'h03, 16'h0002);
    clr();
    wr(ADDR_CTRL, 16'h0003);
    i_cpu.idle(3);
    wr(ADDR_CTRL, 16'h0002);
    rd_chk(ADDR_FLAGS, 16'h0004, 16'h0005);
    clr();
    wr(ADDR_CTRL, 16'h0003);
    i_cpu.idle(5);
    wr(ADDR_CTRL, 16'h0002);
    rd_chk(ADDR_FLAGS, 16'h0005, 16'h0005);
    rd_chk(ADDR_CNT, 16'h0000, 16'hFFFC);
    $display("test center mode done");
    // both channels capture with the same edge selection
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CH_BASE, 16'(s << 2));
      wr(ADDR_CH_BASE + 8'h02, 16'(s << 2));
      clr();
      ch_in <= '1;
      pause();
      rd_chk(ADDR_FLAGS, {13'h0000, s[0], s[0], 1'b0}, 16'h0006);
      clr();
      ch_in <= '0;
      pause();
      rd_chk(ADDR_FLAGS, {13'h0000, s[1], s[1], 1'b0}, 16'h0006);
    end
    pause();
    $display("test capture edges done");
    // prescale 1: one count every two clocks over 2 * gap + 8 running clocks
    wr(ADDR_CNT, 16'h0000);
    wr(ADDR_MOD, MOD_RESET);
    gap = 1 + ($random(seed) & 3);
    wr(ADDR_CTRL, 16'h0005);
    i_cpu.idle(2 * gap + 7);
    wr(ADDR_CTRL, 16'h0000);
    rd_chk(ADDR_CNT, 16'(gap + 4), 16'hFFFF);
    $display("test prescale done");
    // reset in mid-run must drop the channel flags left by the last edges
    wr(ADDR_IRQ_EN, 16'h0006);
    pause();
    irq_chk(1'b1);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(ADDR_FLAGS, 16'h0000, 16'h0007);
    rd_chk(ADDR_IRQ_EN, 16'h0000, 16'hFFFF);
    pause();
    irq_chk(1'b0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule // timer_flags_tb
